// ===== src/mds_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mds_params.svh"
module mds_sequencer
  import mds_pkg::*;
#(
  parameter int DIV_W    = 4,
  parameter int PLLDIV_W = 6
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // external pins
  input  wire logic                alignPulse,
  input  wire logic                framePulse,
  input  wire logic                extStrobe,
  input  wire logic                txGatePin,
  // configuration words
  input  wire logic [15:0]         configurationWordZero,
  input  wire logic [15:0]         configurationWordOne,
  input  wire logic [15:0]         configurationWordSixteen,
  input  wire logic [15:0]         configurationWordTwentyFour,
  input  wire logic [15:0]         configurationWordThirtyOne,
  input  wire logic [15:0]         configurationWordThirtyTwo,
  input  wire logic                pllEnable,
  input  wire logic                dualSyncMode,
  input  wire logic                sifTxEnable,
  input  wire logic [PLLDIV_W-1:0] pllDivLast,
  // status and sync outputs
  output logic                     dualChannel,
  output logic                     wrPtrReset,
  output logic                     rdPtrReset,
  output logic                     fmtReset,
  output logic                     divReset,
  output logic                     pllDivReset,
  output logic [DIV_W-1:0]         divPhase,
  output logic                     internalStrobe,
  output logic                     txActive,
  output mds_state_t               seqState
);

  logic rstMeta;
  logic rstSync;
  // reset release through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // pin synchronisers, three stages, change when stages two and three agree
  logic [3:0] pinS1_q, pinS2_q, pinS3_q, pinV_q;
  logic [3:0] pinV_d;
  logic [3:0] pinRaw;
  assign pinRaw = {txGatePin, extStrobe, framePulse, alignPulse};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSync
      always_comb begin
        pinV_d[gi] = (pinS2_q[gi] == pinS3_q[gi]) ? pinS3_q[gi] : pinV_q[gi];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      pinS1_q <= 4'h0;
      pinS2_q <= 4'h0;
      pinS3_q <= 4'h0;
      pinV_q  <= 4'h0;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinV_q  <= pinV_d;
    end
  end

  // rising edges of filtered pins
  logic [3:0] pinPrev_q;
  logic [3:0] pinRise;
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) pinPrev_q <= 4'h0;
    else          pinPrev_q <= pinV_q;
  end
  assign pinRise = pinV_q & ~pinPrev_q;
  logic alignRise, frameRise, strobeRise;
  assign alignRise  = pinRise[0];
  assign frameRise  = pinRise[1];
  assign strobeRise = pinRise[2];

  // configuration field decode
  logic [3:0] wrSrc, rdSrc;
  logic [1:0] fmtSrc;
  logic       divSrcStrobe, divSyncEn, pllSyncEn;
  assign wrSrc  = configurationWordThirtyTwo[`MDS_CW32_WR_HI:`MDS_CW32_WR_LO];
  assign rdSrc  = configurationWordThirtyTwo[`MDS_CW32_RD_HI:`MDS_CW32_RD_LO];
  assign fmtSrc = configurationWordThirtyOne[`MDS_CW31_FMT_HI:`MDS_CW31_FMT_LO];
  assign divSrcStrobe = configurationWordThirtyTwo[`MDS_CW32_DIVSRC_BIT];
  assign divSyncEn    = configurationWordZero[`MDS_CW0_DIVSYNC_EN_BIT];
  assign pllSyncEn    = configurationWordTwentyFour[`MDS_CW24_PLLSYNC_EN_BIT];
  assign dualChannel  = !configurationWordOne[`MDS_CW1_QUAD_BIT] &&
                        (configurationWordSixteen[`MDS_CW16_CHSEL_HI:`MDS_CW16_CHSEL_LO]
                         == `MDS_CW16_DUAL_VAL);

  // pll feedback divider and internal strobe
  logic [PLLDIV_W-1:0] pllCnt_q, pllCnt_d;
  logic                pllRst_q, pllRst_d;
  logic                intStb_q, intStb_d;
  always_comb begin
    pllRst_d = pllEnable && pllSyncEn && alignRise;
    if (pllRst_d) pllCnt_d = PLLDIV_W'(`MDS_PLLDIV_RESET_VAL);
    else if (pllCnt_q == pllDivLast) pllCnt_d = PLLDIV_W'(`MDS_PLLDIV_RESET_VAL);
    else pllCnt_d = pllCnt_q + 1'b1;
    intStb_d = pllEnable && !pllRst_d && (pllCnt_q == pllDivLast);
  end
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      pllCnt_q <= PLLDIV_W'(`MDS_PLLDIV_RESET_VAL);
      pllRst_q <= 1'b0;
      intStb_q <= 1'b0;
    end else begin
      pllCnt_q <= pllCnt_d;
      pllRst_q <= pllRst_d;
      intStb_q <= intStb_d;
    end
  end
  assign pllDivReset    = pllRst_q;
  assign internalStrobe = intStb_q;

  // effective strobe: internal in pll mode, external pin otherwise
  logic strobeEv;
  assign strobeEv = pllEnable ? intStb_q : strobeRise;

  // source selection
  function automatic logic srcHit(input logic [3:0] sel, input logic fr,
                                  input logic al, input logic st);
    case (sel)
      `MDS_SRC_FRAME:  srcHit = fr;
      `MDS_SRC_ALIGN:  srcHit = al;
      `MDS_SRC_STROBE: srcHit = st;
      default:         srcHit = 1'b0; // off code and unused codes
    endcase
  endfunction : srcHit

  // pointer, formatter and divider sync
  logic wrHit, rdHit, fmtHit, divHit;
  logic wrR_q, rdR_q, fmtR_q, divR_q, wrHand_q;
  logic wrR_d, rdR_d, fmtR_d, divR_d;
  logic [DIV_W-1:0] div_q, div_d;
  always_comb begin
    wrHit  = srcHit(wrSrc, frameRise, alignRise, strobeEv);
    rdHit  = srcHit(rdSrc, frameRise, alignRise, strobeEv);
    fmtHit = (fmtSrc == `MDS_FMT_FRAME) ? frameRise :
             (fmtSrc == `MDS_FMT_ALIGN) ? alignRise : 1'b0;
    divHit = divSyncEn && (divSrcStrobe ? strobeEv : (frameRise | alignRise));
    wrR_d  = wrHit;
    if (dualSyncMode) rdR_d = rdHit;
    else              rdR_d = wrHand_q;
    fmtR_d = fmtHit;
    divR_d = divHit;
    if (divHit) div_d = DIV_W'(`MDS_DIV_RESET_VAL);
    else        div_d = div_q + 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      wrR_q    <= 1'b0;
      wrHand_q <= 1'b0;
      rdR_q    <= 1'b0;
      fmtR_q   <= 1'b0;
      divR_q   <= 1'b0;
      div_q    <= DIV_W'(`MDS_DIV_RESET_VAL);
    end else begin
      wrR_q    <= wrR_d;
      wrHand_q <= wrR_q; // resample of write pointer reset
      rdR_q    <= rdR_d;
      fmtR_q   <= fmtR_d;
      divR_q   <= divR_d;
      div_q    <= div_d;
    end
  end
  assign wrPtrReset = wrR_q;
  assign rdPtrReset = rdR_q;
  assign fmtReset   = fmtR_q;
  assign divReset   = divR_q;
  assign divPhase   = div_q;

  // sequencer state and transmit gating
  mds_state_t st_q, st_d;
  logic tx_q, tx_d;
  always_comb begin
    tx_d = pinV_q[3] || sifTxEnable;
    st_d = st_q;
    case (st_q)
      MDS_IDLE:   if (divSyncEn || pllSyncEn) st_d = MDS_ARMED;
      MDS_ARMED:  if (divR_q || rdR_q) st_d = MDS_SYNCED;
      MDS_SYNCED: if (tx_d) st_d = MDS_RUN;
      MDS_RUN:    if (!tx_d) st_d = MDS_IDLE;
      default:    st_d = MDS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      st_q <= MDS_IDLE;
      tx_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tx_q <= tx_d;
    end
  end
  assign txActive = tx_q;
  assign seqState = st_q;

endmodule : mds_sequencer
`default_nettype wire

// ===== include/mds_params.svh
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH
// configuration field positions
`define MDS_CW0_DIVSYNC_EN_BIT    2
`define MDS_CW1_QUAD_BIT          8
`define MDS_CW16_CHSEL_HI         13
`define MDS_CW16_CHSEL_LO         12
`define MDS_CW16_DUAL_VAL         2'h3
`define MDS_CW24_PLLSYNC_EN_BIT   11
`define MDS_CW27_FUSE_SLEEP_BIT   11
`define MDS_CW31_FMT_HI           3
`define MDS_CW31_FMT_LO           2
`define MDS_CW32_WR_HI            15
`define MDS_CW32_WR_LO            12
`define MDS_CW32_RD_HI            11
`define MDS_CW32_RD_LO            8
`define MDS_CW32_DIVSRC_BIT       0
// sync source codes
`define MDS_SRC_OFF               4'h0
`define MDS_SRC_FRAME             4'h1
`define MDS_SRC_ALIGN             4'h2
`define MDS_SRC_STROBE            4'h4
`define MDS_FMT_FRAME             2'h0
`define MDS_FMT_ALIGN             2'h1
// defaults
`define MDS_DIV_RESET_VAL         4'h0
`define MDS_PLLDIV_RESET_VAL      6'h00
`endif

// ===== include/mds_pkg.sv
package mds_pkg;
  // sequencer phase
  typedef enum logic [1:0] {
    MDS_IDLE   = 2'b00,
    MDS_ARMED  = 2'b01,
    MDS_SYNCED = 2'b11,
    MDS_RUN    = 2'b10
  } mds_state_t;
endpackage : mds_pkg

// ===== bench/mds_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mds_sequencer_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // controls
  input wire logic        txGatePin,
  input wire logic        sifTxEnable,
  input wire logic        pllEnable,
  input wire logic        dualSyncMode,
  input wire logic [15:0] configurationWordZero,
  input wire logic [15:0] configurationWordOne,
  input wire logic [15:0] configurationWordSixteen,
  input wire logic [15:0] configurationWordTwentyFour,
  input wire logic [15:0] configurationWordThirtyTwo,
  // watched outputs
  input wire logic        dualChannel,
  input wire logic        wrPtrReset,
  input wire logic        rdPtrReset,
  input wire logic        divReset,
  input wire logic        pllDivReset,
  input wire logic        txActive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // decode, pointer handoff, gating, pll pulse width and transmit start and stop
  chk_dual_decode: assert property (
    dualChannel == (!configurationWordOne[8] && configurationWordSixteen[13:12] == 2'h3))
    else $error("dual channel decode wrong");
  chk_rd_follow: assert property (
    !dualSyncMode && wrPtrReset |-> ##2 rdPtrReset) else $error("read reset not handed over");
  chk_rd_source: assert property (
    pllEnable && !dualSyncMode && rdPtrReset |-> $past(wrPtrReset, 2))
    else $error("read reset from strobe");
  chk_wr_off: assert property (
    configurationWordThirtyTwo[15:12] == 4'h0 && $past(configurationWordThirtyTwo[15:12]) == 4'h0
    |-> !wrPtrReset) else $error("write reset while off");
  chk_div_gate: assert property (
    !configurationWordZero[2] && !$past(configurationWordZero[2]) |-> !divReset)
    else $error("divider synced while disabled");
  chk_pll_gate: assert property (
    !configurationWordTwentyFour[11] && !$past(configurationWordTwentyFour[11]) |-> !pllDivReset)
    else $error("pll divider reset while disabled");
  chk_pll_once: assert property (
    pllDivReset |=> !pllDivReset) else $error("pll reset longer than a pulse");
  chk_tx_on: assert property (
    sifTxEnable [*6] |-> txActive) else $error("transmit not started");
  chk_tx_off: assert property (
    (!txGatePin && !sifTxEnable) [*8] |-> !txActive) else $error("transmit without enable");
endmodule : mds_sequencer_asserts
bind mds_sequencer mds_sequencer_asserts chk (.*);
`default_nettype wire

// ===== bench/mds_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module mds_source_model (
  // pins toward the sequencer
  input wire logic ref_clk,
  output logic     alignPulse,
  output logic     framePulse,
  output logic     extStrobe
);
  logic [2:0] pins = 3'h0;
  assign {extStrobe, framePulse, alignPulse} = pins;
  // one rising edge from the clock domain, held three cycles
  task automatic send(input int k);
    @(negedge ref_clk) pins[k] = 1'b1;
    repeat (3) @(negedge ref_clk);
    pins[k] = 1'b0;
  endtask : send
endmodule : mds_source_model
`default_nettype wire

// ===== bench/test_mds_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mds_params.svh"
module test_mds_sequencer;
  import mds_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, txGatePin = 1'b0, sifTxEnable = 1'b0;
  logic pllEnable = 1'b0, dualSyncMode = 1'b0;
  logic [15:0] configurationWordZero = 16'h0, configurationWordOne = 16'h0;
  logic [15:0] configurationWordSixteen = 16'h0, configurationWordTwentyFour = 16'h0;
  logic [15:0] configurationWordThirtyOne = 16'h0, configurationWordThirtyTwo = 16'h0;
  logic [5:0] pllDivLast = 6'h03;
  logic [15:0] configurationWordTwentySeven = 16'h0;
  wire logic alignPulse, framePulse, extStrobe, dualChannel, wrPtrReset, rdPtrReset;
  wire logic fmtReset, divReset, pllDivReset, internalStrobe, txActive;
  wire logic [3:0] divPhase;
  mds_state_t seqState;
  int failures = 0, n_compared = 0, n;
  mds_source_model src (.*);
  mds_sequencer uut (.*);
  always #5 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // program sources and enables, then let them settle
  task automatic cfg(input logic [3:0] w, r, input logic [1:0] f, input logic ds, de, ps, pe, dm);
    @(negedge ref_clk);
    configurationWordThirtyTwo = {w, r, 7'h00, ds};
    configurationWordThirtyOne = {12'h000, f, 2'h0};
    configurationWordZero = {13'h0000, de, 2'h0};
    configurationWordTwentyFour = {4'h0, ps, 11'h000};
    pllEnable = pe;
    dualSyncMode = dm;
    repeat (3) @(negedge ref_clk);
  endtask : cfg
  // one pin edge, then gather every sync pulse
  task automatic fire(input int k, input logic [4:0] exp);
    logic [4:0] seen;
    seen = 5'h00;
    src.send(k);
    repeat (12) begin
      @(negedge ref_clk);
      seen |= {wrPtrReset, rdPtrReset, fmtReset, divReset, pllDivReset};
    end
    chk({11'h000, seen}, {11'h000, exp});
  endtask : fire
  // main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({15'h0, txActive}, 16'h0000);
    chk({14'h0, seqState}, {14'h0, MDS_IDLE});
    for (int i = 0; i < 2; i++) begin
      configurationWordOne = i ? 16'h0100 : 16'h0000;
      configurationWordSixteen = 16'h3000;
      @(negedge ref_clk);
      chk({15'h0, dualChannel}, {15'h0, i == 0});
    end
    configurationWordTwentySeven[`MDS_CW27_FUSE_SLEEP_BIT] = 1'b1;
    cfg(`MDS_SRC_FRAME, `MDS_SRC_FRAME, `MDS_FMT_FRAME, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    fire(1, 5'h1e);
    chk({14'h0, seqState}, {14'h0, MDS_SYNCED});
    chk({12'h000, divPhase}, 16'h000a);
    fire(0, 5'h02);
    chk({12'h000, divPhase}, 16'h000a);
    cfg(`MDS_SRC_OFF, `MDS_SRC_OFF, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    fire(1, 5'h00);
    chk({12'h000, divPhase}, 16'h000e);
    cfg(`MDS_SRC_OFF, `MDS_SRC_OFF, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    fire(0, 5'h01);
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      if (internalStrobe === 1'b1) n++;
    end
    chk(16'(n), 16'h000a);
    cfg(`MDS_SRC_ALIGN, `MDS_SRC_STROBE, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    fire(2, 5'h00);
    fire(0, 5'h18);
    // pll with dual sources: align the pll dividers, then sync from the internal strobe
    cfg(`MDS_SRC_OFF, `MDS_SRC_OFF, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    fire(0, 5'h01);
    cfg(`MDS_SRC_ALIGN, `MDS_SRC_STROBE, `MDS_FMT_ALIGN, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    fire(0, 5'h1e);
    cfg(`MDS_SRC_FRAME, `MDS_SRC_STROBE, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    fire(2, 5'h0a);
    fire(1, 5'h10);
    cfg(`MDS_SRC_FRAME, `MDS_SRC_STROBE, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    fire(2, 5'h08);
    sifTxEnable = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({15'h0, txActive}, 16'h0001);
    chk({14'h0, seqState}, {14'h0, MDS_RUN});
    // gate dropped: sequencer falls back, then a full resync before restart
    sifTxEnable = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({15'h0, txActive}, 16'h0000);
    chk({14'h0, seqState}, {14'h0, MDS_IDLE});
    cfg(`MDS_SRC_FRAME, `MDS_SRC_STROBE, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    fire(2, 5'h0a);
    txGatePin = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({15'h0, txActive}, 16'h0001);
    chk({14'h0, seqState}, {14'h0, MDS_RUN});
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
endmodule : test_mds_sequencer
`default_nettype wire
